// >>> src/pi_port_regs.vh
/*
  Register offsets, field positions, reset values and handshake timing
  for the two-port mode 0 parallel block.
  Assumes a 32-bit Avalon-MM slave with word addresses; only the low
  byte of each register is used.
*/
`ifndef PI_PORT_REGS_VH
`define PI_PORT_REGS_VH

// Word addresses of the registers.
`define ADDR_GENERAL_CONTROL 4'h0
`define ADDR_PORT_STATUS 4'h1
`define ADDR_PORT_A_CONTROL 4'h2
`define ADDR_PORT_B_CONTROL 4'h3
`define ADDR_PORT_A_DATA 4'h4
`define ADDR_PORT_B_DATA 4'h5
`define ADDR_PORT_A_DIRECTION 4'h6
`define ADDR_PORT_B_DIRECTION 4'h7

// Reset values.
`define RESET_CONTROL 8'h00
`define RESET_GENERAL 8'h00
`define RESET_BYTE 8'h00

// Port control register fields.
`define CTL_SUBMODE_HI 7
`define CTL_SUBMODE_LO 6
`define CTL_SEC_HI 5
`define CTL_SEC_LO 3
`define CTL_SEC_IRQ_EN 2
`define CTL_PRI_SVC_EN 1
`define CTL_PRI_STATUS 0

// General control fields: pair enables and asserted sense of each pin.
`define GEN_PAIR_EN_A 0
`define GEN_PAIR_EN_B 1
`define GEN_SENSE_LO 4

// Status register fields; port B sits two bits above port A.
`define STAT_PRIMARY 0
`define STAT_SECONDARY 1

// Handshake timing in clock cycles.
`define HS_ASSERT_DELAY 3'd2
`define HS_PULSE_MAX 3'd4

`endif

// >>> src/edge_sync.v
/*
  Two-flop synchroniser and asserted-edge detector for one handshake pin.
  Assumes the pin is asynchronous to clock and sense is a steady level.
*/
`timescale 1ns/10ps
module edge_sync
(
  input wire clock,
  input wire rst,
  input wire pin,
  input wire sense,
  output wire asserted_edge
);
  reg meta;
  reg sampled;
  reg previous;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      sampled <= 1'b0;
      previous <= 1'b0;
    end
    else
    begin
      meta <= pin;
      sampled <= meta;
      previous <= sampled;
    end
  end

  // Only the second and third stages feed the comparison.
  assign asserted_edge = (sampled ~^ sense) & ~(previous ~^ sense);
endmodule // edge_sync

// >>> src/out_latch_pair.v
/*
  Initial and final output latch pair of one double-buffered port.
  Assumes load and take are one-cycle pulses from the same clock.
*/
`timescale 1ns/10ps
`include "pi_port_regs.vh"
module out_latch_pair
(
  input wire clock,
  input wire rst,
  input wire load,
  input wire [7:0] load_data,
  input wire take,
  output reg [7:0] final_data,
  output reg initial_full,
  output reg final_full,
  output reg final_loaded
);
  reg [7:0] initial_data;
  reg next_initial_full;
  reg next_final_full;
  reg move_initial;
  reg load_final;
  reg load_initial;

  // A take frees the final latch before a load in the same cycle looks
  // for room, so a full pair still accepts a write as it drains.
  always @*
  begin
    next_initial_full = initial_full;
    next_final_full = final_full;
    move_initial = 1'b0;
    load_final = 1'b0;
    load_initial = 1'b0;
    if (take && final_full)
    begin
      next_final_full = initial_full;
      next_initial_full = 1'b0;
      move_initial = initial_full;
    end
    // A write with both latches full and no take in the same cycle is dropped.
    if (load && !next_final_full)
    begin
      next_final_full = 1'b1;
      load_final = 1'b1;
    end
    else if (load && !next_initial_full)
    begin
      next_initial_full = 1'b1;
      load_initial = 1'b1;
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      initial_data <= `RESET_BYTE;
      final_data <= `RESET_BYTE;
      initial_full <= 1'b0;
      final_full <= 1'b0;
      final_loaded <= 1'b0;
    end
    else
    begin
      initial_full <= next_initial_full;
      final_full <= next_final_full;
      final_loaded <= move_initial | load_final;
      if (load_final)
        final_data <= load_data;
      else if (move_initial)
        final_data <= initial_data;
      if (load_initial)
        initial_data <= load_data;
    end
  end
endmodule // out_latch_pair

// >>> src/pi_port_mode0.v
/*
  Mode 0 control and status logic of two 8-bit parallel ports, with an
  Avalon-MM register slave, output latches, handshake pins and status.
  Assumes pins are asynchronous to clock and software programs each port
  control register only while that port's pair enable is clear.
*/
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "pi_port_regs.vh"

module pi_port_mode0
(
  input wire clock,
  input wire rst,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire [15:0] port_pin_in,
  output wire [15:0] port_pin_out,
  output wire [15:0] port_pin_oe_n,
  input wire port_a_primary_strobe,
  input wire port_b_primary_strobe,
  input wire port_a_secondary_handshake_in,
  input wire port_b_secondary_handshake_in,
  output wire port_a_secondary_handshake_out,
  output wire port_b_secondary_handshake_out,
  output wire port_a_secondary_handshake_oe_n,
  output wire port_b_secondary_handshake_oe_n,
  output wire service_request,
  output wire [1:0] dma_request
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_ASSERT = 3'b100;

  reg [7:0] port_a_control;
  reg [7:0] port_b_control;
  reg [7:0] port_general_control;
  reg [7:0] port_a_direction;
  reg [7:0] port_b_direction;
  reg [7:0] port_a_bit_data;
  reg [7:0] port_b_bit_data;
  reg bus_ack;
  reg [15:0] pin_meta;
  reg [15:0] pin_sampled;
  wire bus_write;
  wire bus_read_start;
  wire [1:0] pair_enable;
  wire [3:0] sense;
  wire [1:0] primary_edge;
  wire [1:0] secondary_edge;
  wire [1:0] primary_flag;
  wire [1:0] secondary_flag;
  wire [1:0] secondary_out;
  wire [1:0] secondary_oe_n;
  wire [15:0] final_data;
  wire [1:0] status_clear_primary;
  wire [1:0] status_clear_secondary;
  wire [1:0] data_write;
  wire [7:0] port_status;

  // Submode field of a port control register.
  function [1:0] submode;
    input [7:0] ctl;
    begin
      submode = ctl[`CTL_SUBMODE_HI:`CTL_SUBMODE_LO];
    end
  endfunction

  // True when the port runs double-buffered output.
  function is_dbl_out;
    input [7:0] ctl;
    begin
      is_dbl_out = (submode(ctl) == 2'b01);
    end
  endfunction

  // True when the port runs bit I/O.
  function is_bit_io;
    input [7:0] ctl;
    begin
      is_bit_io = ctl[`CTL_SUBMODE_HI];
    end
  endfunction

  // Byte read back from a data register for submodes 01 and 1X.
  function [7:0] data_view;
    input [7:0] dir;
    input [7:0] latched;
    input [7:0] pins;
    begin
      data_view = (dir & latched) | (~dir & pins);
    end
  endfunction

  // One wait cycle per access, so read data are registered.
  assign waitrequest = (read | write) & ~bus_ack;
  assign bus_write = write & bus_ack & byteenable[0];
  assign bus_read_start = read & ~bus_ack;

  assign pair_enable[0] = port_general_control[`GEN_PAIR_EN_A];
  assign pair_enable[1] = port_general_control[`GEN_PAIR_EN_B];
  assign sense = port_general_control[`GEN_SENSE_LO+3:`GEN_SENSE_LO];

  assign data_write[0] = bus_write && address == `ADDR_PORT_A_DATA;
  assign data_write[1] = bus_write && address == `ADDR_PORT_B_DATA;
  assign status_clear_primary[0] = bus_write &&
    address == `ADDR_PORT_STATUS && writedata[`STAT_PRIMARY];
  assign status_clear_secondary[0] = bus_write &&
    address == `ADDR_PORT_STATUS && writedata[`STAT_SECONDARY];
  assign status_clear_primary[1] = bus_write &&
    address == `ADDR_PORT_STATUS && writedata[`STAT_PRIMARY+2];
  assign status_clear_secondary[1] = bus_write &&
    address == `ADDR_PORT_STATUS && writedata[`STAT_SECONDARY+2];

  assign port_status = {4'h0, secondary_flag[1], primary_flag[1],
    secondary_flag[0], primary_flag[0]};

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bus_ack <= 1'b0;
      port_a_control <= `RESET_CONTROL;
      port_b_control <= `RESET_CONTROL;
      port_general_control <= `RESET_GENERAL;
      port_a_direction <= `RESET_BYTE;
      port_b_direction <= `RESET_BYTE;
      port_a_bit_data <= `RESET_BYTE;
      port_b_bit_data <= `RESET_BYTE;
      readdata <= 32'h0000_0000;
      pin_meta <= 16'h0000;
      pin_sampled <= 16'h0000;
    end
    else
    begin
      bus_ack <= (read | write) & ~bus_ack;
      pin_meta <= port_pin_in;
      pin_sampled <= pin_meta;
      if (bus_write)
      begin
        case (address)
          `ADDR_GENERAL_CONTROL: port_general_control <= writedata[7:0];
          `ADDR_PORT_A_CONTROL: port_a_control <= writedata[7:0];
          `ADDR_PORT_B_CONTROL: port_b_control <= writedata[7:0];
          `ADDR_PORT_A_DIRECTION: port_a_direction <= writedata[7:0];
          `ADDR_PORT_B_DIRECTION: port_b_direction <= writedata[7:0];
          `ADDR_PORT_A_DATA: port_a_bit_data <= writedata[7:0];
          `ADDR_PORT_B_DATA: port_b_bit_data <= writedata[7:0];
          default: ;
        endcase
      end
      if (bus_read_start)
      begin
        case (address)
          `ADDR_GENERAL_CONTROL: readdata <= {24'h00_0000,
            port_general_control};
          `ADDR_PORT_STATUS: readdata <= {24'h00_0000, port_status};
          `ADDR_PORT_A_CONTROL: readdata <= {24'h00_0000, port_a_control};
          `ADDR_PORT_B_CONTROL: readdata <= {24'h00_0000, port_b_control};
          `ADDR_PORT_A_DIRECTION: readdata <= {24'h00_0000,
            port_a_direction};
          `ADDR_PORT_B_DIRECTION: readdata <= {24'h00_0000,
            port_b_direction};
          `ADDR_PORT_A_DATA: readdata <= {24'h00_0000,
            data_view(port_a_direction, is_bit_io(port_a_control) ?
            port_a_bit_data : final_data[7:0], pin_sampled[7:0])};
          `ADDR_PORT_B_DATA: readdata <= {24'h00_0000,
            data_view(port_b_direction, is_bit_io(port_b_control) ?
            port_b_bit_data : final_data[15:8], pin_sampled[15:8])};
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  edge_sync u_a_primary
  (
    .clock(clock),
    .rst(rst),
    .pin(port_a_primary_strobe),
    .sense(sense[0]),
    .asserted_edge(primary_edge[0])
  );

  edge_sync u_b_primary
  (
    .clock(clock),
    .rst(rst),
    .pin(port_b_primary_strobe),
    .sense(sense[2]),
    .asserted_edge(primary_edge[1])
  );

  edge_sync u_a_secondary
  (
    .clock(clock),
    .rst(rst),
    .pin(port_a_secondary_handshake_in),
    .sense(sense[1]),
    .asserted_edge(secondary_edge[0])
  );

  edge_sync u_b_secondary
  (
    .clock(clock),
    .rst(rst),
    .pin(port_b_secondary_handshake_in),
    .sense(sense[3]),
    .asserted_edge(secondary_edge[1])
  );

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : port
      wire [7:0] ctl;
      wire [7:0] dir;
      wire [7:0] bit_data;
      wire [2:0] sec_mode;
      wire dbl_out;
      wire bit_io;
      wire protocol;
      wire take;
      wire initial_full;
      wire final_full;
      wire final_loaded;
      wire level_flag;
      wire sec_asserted;
      reg [2:0] state;
      reg [2:0] count;
      reg primary_sticky;
      reg secondary_sticky;

      assign ctl = (p == 0) ? port_a_control : port_b_control;
      assign dir = (p == 0) ? port_a_direction : port_b_direction;
      assign bit_data = (p == 0) ? port_a_bit_data : port_b_bit_data;
      assign sec_mode = ctl[`CTL_SEC_HI:`CTL_SEC_LO];
      assign dbl_out = is_dbl_out(ctl);
      assign bit_io = is_bit_io(ctl);
      assign protocol = dbl_out && sec_mode[2] && sec_mode[1];

      // With the secondary field at 11X, strobes only move data while the handshake pin is asserted.
      assign take = dbl_out && primary_edge[p] &&
        (!protocol || state == ST_ASSERT);

      out_latch_pair u_latch
      (
        .clock(clock),
        .rst(rst),
        .load(data_write[p] && dbl_out),
        .load_data(writedata[7:0]),
        .take(take | (state == ST_ASSERT && sec_mode[0] &&
          count == `HS_PULSE_MAX - 3'd1)),
        .final_data(final_data[8*p+7:8*p]),
        .initial_full(initial_full),
        .final_full(final_full),
        .final_loaded(final_loaded)
      );

      always @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          state <= ST_IDLE;
          count <= 3'd0;
          primary_sticky <= 1'b0;
          secondary_sticky <= 1'b0;
        end
        else
        begin
          if (!protocol || !pair_enable[p])
          begin
            state <= ST_IDLE;
            count <= 3'd0;
          end
          else
          begin
            case (state)
              ST_IDLE:
              begin
                count <= 3'd0;
                if (final_loaded)
                  state <= ST_WAIT;
              end
              ST_WAIT:
              begin
                count <= count + 3'd1;
                if (count == `HS_ASSERT_DELAY - 3'd2)
                begin
                  state <= ST_ASSERT;
                  count <= 3'd0;
                end
              end
              ST_ASSERT:
              begin
                count <= count + 3'd1;
                if (primary_edge[p])
                  state <= ST_IDLE;
                else if (sec_mode[0] && count == `HS_PULSE_MAX - 3'd1)
                  state <= ST_IDLE;
              end
              default: state <= ST_IDLE;
            endcase
          end
          // Set wins over a clear written in the same cycle.
          if (!pair_enable[p] || !bit_io)
            primary_sticky <= 1'b0;
          else if (primary_edge[p])
            primary_sticky <= 1'b1;
          else if (status_clear_primary[p])
            primary_sticky <= 1'b0;
          if (!pair_enable[p] || sec_mode[2] || !(dbl_out || bit_io))
            secondary_sticky <= 1'b0;
          else if (secondary_edge[p])
            secondary_sticky <= 1'b1;
          else if (status_clear_secondary[p])
            secondary_sticky <= 1'b0;
        end
      end

      // Port B takes its status choice from its own control register, as port A does.
      assign level_flag = ctl[`CTL_PRI_STATUS] ?
        (!initial_full && !final_full) :
        !(initial_full && final_full);
      assign primary_flag[p] = bit_io ? primary_sticky :
        (dbl_out && level_flag);
      assign secondary_flag[p] = secondary_sticky;

      // The strobe edge negates the pin in the same cycle it is seen.
      assign sec_asserted = protocol ?
        (pair_enable[p] && state == ST_ASSERT && !primary_edge[p]) :
        sec_mode[0];
      assign secondary_out[p] = sec_asserted ~^ sense[2*p+1];
      assign secondary_oe_n[p] = !(sec_mode[2] && (dbl_out || bit_io));

      assign port_pin_out[8*p+7:8*p] = bit_io ? bit_data :
        final_data[8*p+7:8*p];
      assign port_pin_oe_n[8*p+7:8*p] = (dbl_out || bit_io) ? ~dir :
        8'hff;

      // Bit I/O raises no DMA request.
      assign dma_request[p] = dbl_out && ctl[`CTL_PRI_SVC_EN] &&
        primary_flag[p];
    end
  endgenerate

  assign service_request =
    (primary_flag[0] && port_a_control[`CTL_PRI_SVC_EN]) ||
    (primary_flag[1] && port_b_control[`CTL_PRI_SVC_EN]) ||
    (secondary_flag[0] && port_a_control[`CTL_SEC_IRQ_EN]) ||
    (secondary_flag[1] && port_b_control[`CTL_SEC_IRQ_EN]);

  assign port_a_secondary_handshake_out = secondary_out[0];
  assign port_b_secondary_handshake_out = secondary_out[1];
  assign port_a_secondary_handshake_oe_n = secondary_oe_n[0];
  assign port_b_secondary_handshake_oe_n = secondary_oe_n[1];
endmodule // pi_port_mode0

// >>> tb/pi_port_mode0_asserts.sv
/*
  Concurrent checks on the bus and handshake pins of the mode 0 port block.
  Assumes it is bound to that block and sees only its ports.
*/
`timescale 1ns/10ps
`include "pi_port_regs.vh"
module pi_port_mode0_asserts
(
  input wire clock,
  input wire rst,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire port_a_secondary_handshake_out,
  input wire port_b_secondary_handshake_out,
  input wire port_a_secondary_handshake_oe_n,
  input wire port_b_secondary_handshake_oe_n,
  input wire service_request,
  input wire [1:0] dma_request
);
  // Shadows follow bus writes, because the registers are not ports.
  logic [7:0] ctl_a;
  logic [7:0] ctl_b;
  logic [7:0] gen;
  logic [2:0] pulse_cnt;
  wire wr = write && !waitrequest && byteenable[0];
  wire a_on = !port_a_secondary_handshake_oe_n &&
    port_a_secondary_handshake_out == gen[5];
  wire b_on = !port_b_secondary_handshake_oe_n && ctl_b[7:3] == 5'h0f &&
    port_b_secondary_handshake_out == gen[7];
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctl_a <= 8'h00;
      ctl_b <= 8'h00;
      gen <= 8'h00;
      pulse_cnt <= 3'h0;
    end
    else
    begin
      if (wr && address == `ADDR_PORT_A_CONTROL)
        ctl_a <= writedata[7:0];
      if (wr && address == `ADDR_PORT_B_CONTROL)
        ctl_b <= writedata[7:0];
      if (wr && address == `ADDR_GENERAL_CONTROL)
        gen <= writedata[7:0];
      pulse_cnt <= b_on ? pulse_cnt + 3'h1 : 3'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wait_answer_a: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one wait cycle");
  read_upper_a: assert property (
    read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  sec_static_a: assert property (
    gen[0] && ctl_a[7:6] != 2'h0 && ctl_a[5] && (ctl_a[7] || !ctl_a[4])
    |-> !port_a_secondary_handshake_oe_n &&
    port_a_secondary_handshake_out == (ctl_a[3] ~^ gen[5]))
    else $error("static secondary output level wrong");
  sec_flag_a: assert property (
    read && !waitrequest && address == `ADDR_PORT_STATUS && ctl_a[5] &&
    ctl_a[7:6] != 2'h0 |-> !readdata[1])
    else $error("secondary flag set while pin is an output");
  dma_gate_a: assert property (
    dma_request[0] |-> ctl_a[7:6] == 2'h1 && ctl_a[1])
    else $error("dma request outside enabled double-buffered mode");
  irq_gate_a: assert property (
    ctl_a[2:1] == 2'h0 && ctl_b[2:1] == 2'h0 |-> !service_request)
    else $error("service request with all enables clear");
  pulse_len_a: assert property (
    b_on |-> pulse_cnt < 3'h4)
    else $error("pulsed handshake longer than four clocks");
  assert_delay_a: assert property (
    wr && address == `ADDR_PORT_A_DATA && ctl_a[7:3] == 5'h0e && gen[0] &&
    !a_on |-> ##[1:3] a_on)
    else $error("interlocked handshake not asserted after data load");
  cover property (pulse_cnt == 3'h4);
  cover property (dma_request[1]);
  cover property (service_request && ctl_a[7]);
endmodule // pi_port_mode0_asserts
bind pi_port_mode0 pi_port_mode0_asserts u_checks (.clock, .rst, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .port_a_secondary_handshake_out, .port_b_secondary_handshake_out,
  .port_a_secondary_handshake_oe_n, .port_b_secondary_handshake_oe_n,
  .service_request, .dma_request);

// >>> tb/pi_periph.sv
/*
  Peripheral on one output port: takes each offered byte and strobes back.
  Assumes active-high pin senses and a stall input from the bench.
*/
`timescale 1ns/10ps
module pi_periph
(
  input wire clock,
  input wire hs,
  input wire hs_oe_n,
  input wire [7:0] data,
  input wire hold,
  output logic strobe,
  output logic [7:0] rx_last,
  output logic [7:0] rx_prev,
  output int rx_count
);
  initial
  begin
    strobe = 1'b0;
    rx_last = 8'h00;
    rx_prev = 8'h00;
    rx_count = 0;
    forever
    begin
      @(negedge clock);
      // Strobing a negated handshake does nothing, so we never do it.
      if (hs === 1'b1 && hs_oe_n === 1'b0 && hold === 1'b0)
      begin
        rx_prev = rx_last;
        rx_last = data;
        rx_count++;
        @(posedge clock);
        strobe <= 1'b1;
        repeat (4)
          @(posedge clock);
        strobe <= 1'b0;
        repeat (2)
          @(posedge clock);
      end
    end
  end
endmodule // pi_periph

// >>> tb/parallel_port_mode0_output_bitio_tb.sv
/*
  Self-checking bench of the mode 0 port block with a peripheral per port.
  Assumes the block signals every wait state on waitrequest.
*/
`timescale 1ns/10ps
`include "pi_port_regs.vh"
module parallel_port_mode0_output_bitio_tb;
  logic clock, rst, read, write;
  logic [3:0] address, byteenable, st, o;
  logic [31:0] writedata, q;
  logic [15:0] port_pin_in;
  logic [7:0] c, s;
  logic [1:0] hold;
  wire [31:0] readdata;
  wire waitrequest, service_request;
  wire [15:0] port_pin_out, port_pin_oe_n;
  wire [1:0] ps, dma_request;
  wire [7:0] rx_last [2];
  wire [7:0] rx_prev [2];
  int rx_count [2];
  int n_mismatch, total_checks, i, p;
  wire port_a_secondary_handshake_out, port_b_secondary_handshake_out;
  wire port_a_secondary_handshake_oe_n, port_b_secondary_handshake_oe_n;
  wire port_a_primary_strobe = st[0] | ps[0];
  wire port_a_secondary_handshake_in = st[1];
  wire port_b_primary_strobe = st[2] | ps[1];
  wire port_b_secondary_handshake_in = st[3];
  pi_port_mode0 DUT (.clock, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .port_pin_in, .port_pin_out,
    .port_pin_oe_n, .port_a_primary_strobe, .port_b_primary_strobe,
    .port_a_secondary_handshake_in, .port_b_secondary_handshake_in,
    .port_a_secondary_handshake_out, .port_b_secondary_handshake_out,
    .port_a_secondary_handshake_oe_n, .port_b_secondary_handshake_oe_n,
    .service_request, .dma_request);
  pi_periph peer_a (.clock, .hs(port_a_secondary_handshake_out),
    .hs_oe_n(port_a_secondary_handshake_oe_n), .data(port_pin_out[7:0]),
    .hold(hold[0]), .strobe(ps[0]), .rx_last(rx_last[0]),
    .rx_prev(rx_prev[0]), .rx_count(rx_count[0]));
  pi_periph peer_b (.clock, .hs(port_b_secondary_handshake_out),
    .hs_oe_n(port_b_secondary_handshake_oe_n), .data(port_pin_out[15:8]),
    .hold(hold[1]), .strobe(ps[1]), .rx_last(rx_last[1]),
    .rx_prev(rx_prev[1]), .rx_count(rx_count[1]));
  initial
  begin
    clock = 1'b0;
    forever
      #20 clock = ~clock;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(negedge clock);
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q[7:0] & m, e);
  endtask
  task tpulse(input int k);
    @(posedge clock);
    st[k] <= 1'b1;
    repeat (4)
      @(posedge clock);
    st[k] <= 1'b0;
    repeat (4)
      @(posedge clock);
  endtask
  task out_test(input int pt, input logic [7:0] cv);
    logic [3:0] ao;
    logic [7:0] sm;
    logic [7:0] b0;
    int n;
    ao = pt[3:0];
    sm = 8'h01 << (2 * pt);
    b0 = {ao, cv[3:0]};
    n = rx_count[pt];
    hold[pt] <= 1'b1;
    bus(1'b1, `ADDR_GENERAL_CONTROL, 8'h00);
    bus(1'b1, `ADDR_PORT_A_CONTROL + ao, cv);
    bus(1'b1, `ADDR_PORT_A_DIRECTION + ao, 8'hFF);
    bus(1'b1, `ADDR_GENERAL_CONTROL, 8'hF3);
    chk(port_pin_oe_n[8*pt +: 8], 8'h00);
    rchk(`ADDR_PORT_STATUS, sm, sm);
    bus(1'b1, `ADDR_PORT_A_DATA + ao, b0);
    rchk(`ADDR_PORT_STATUS, sm, cv[0] ? 8'h00 : sm);
    bus(1'b1, `ADDR_PORT_A_DATA + ao, ~b0);
    bus(1'b1, `ADDR_PORT_A_DATA + ao, 8'hEE);
    rchk(`ADDR_PORT_STATUS, sm, 8'h00);
    chk({7'h00, dma_request[pt]}, 8'h00);
    hold[pt] <= 1'b0;
    repeat (300)
      if (rx_count[pt] < n + 2)
        @(posedge clock);
    // The count moves a half cycle before the last strobe is driven, and that strobe must still cross the synchroniser.
    repeat (8)
      @(posedge clock);
    rchk(`ADDR_PORT_STATUS, sm, sm);
    chk(rx_prev[pt], b0);
    chk(rx_last[pt], ~b0);
    chk(8'(rx_count[pt] - n), 8'h02);
    chk({7'h00, dma_request[pt]}, 8'h01);
  endtask
  initial
  begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hF;
    port_pin_in = 16'h0;
    st = 4'h0;
    hold = 2'h3;
    n_mismatch = 0;
    total_checks = 0;
    repeat (2)
      @(posedge clock);
    rst <= 1'b0;
    rchk(`ADDR_PORT_A_CONTROL, 8'hFF, 8'h00);
    rchk(`ADDR_PORT_B_CONTROL, 8'hFF, 8'h00);
    rchk(4'hF, 8'hFF, 8'h00);
    for (p = 0; p < 2; p++)
    begin
      o = p[3:0];
      s = 8'h01 << (2 * p);
      bus(1'b1, `ADDR_PORT_A_CONTROL + o, 8'h87);
      bus(1'b1, `ADDR_PORT_A_DIRECTION + o, 8'h0F);
      bus(1'b1, `ADDR_PORT_A_DATA + o, 8'hA5);
      bus(1'b1, `ADDR_GENERAL_CONTROL, 8'hF3);
      chk(port_pin_oe_n[8*p +: 8], 8'hF0);
      chk(port_pin_out[8*p +: 8] & 8'h0F, 8'h05);
      @(posedge clock);
      port_pin_in[8*p +: 8] <= 8'h3C;
      // Pin levels reach the read path only after the two sync stages.
      repeat (2)
        @(posedge clock);
      rchk(`ADDR_PORT_A_DATA + o, 8'hFF, 8'h35);
      rchk(`ADDR_PORT_STATUS, s * 8'h03, 8'h00);
      tpulse(2 * p);
      rchk(`ADDR_PORT_STATUS, s, s);
      chk({6'h00, service_request, dma_request[p]}, 8'h02);
      bus(1'b1, `ADDR_PORT_STATUS, s);
      rchk(`ADDR_PORT_STATUS, s, 8'h00);
      tpulse(2 * p + 1);
      rchk(`ADDR_PORT_STATUS, s * 8'h02, s * 8'h02);
      chk({7'h00, service_request}, 8'h01);
      tpulse(2 * p);
      bus(1'b1, `ADDR_GENERAL_CONTROL, 8'h00);
      rchk(`ADDR_PORT_STATUS, s * 8'h03, 8'h00);
    end
    bus(1'b1, `ADDR_PORT_A_CONTROL, 8'h40);
    bus(1'b1, `ADDR_GENERAL_CONTROL, 8'hF3);
    tpulse(1);
    rchk(`ADDR_PORT_STATUS, 8'h02, 8'h02);
    for (i = 0; i < 8; i++)
    begin
      c = (i[2] ? 8'h80 : 8'h40) | (i[0] ? 8'h28 : 8'h20);
      bus(1'b1, `ADDR_GENERAL_CONTROL, 8'h00);
      bus(1'b1, `ADDR_PORT_A_CONTROL, c);
      bus(1'b1, `ADDR_GENERAL_CONTROL, i[1] ? 8'hF3 : 8'hD3);
      chk({7'h00, port_a_secondary_handshake_oe_n}, 8'h00);
      chk({7'h00, port_a_secondary_handshake_out},
        {7'h00, i[0] ~^ i[1]});
      tpulse(1);
      rchk(`ADDR_PORT_STATUS, 8'h02, 8'h00);
    end
    for (p = 0; p < 2; p++)
      for (i = 0; i < 2; i++)
        out_test(p, 8'h72 | i[7:0]);
    hold <= 2'h3;
    bus(1'b1, `ADDR_GENERAL_CONTROL, 8'h00);
    bus(1'b1, `ADDR_PORT_B_CONTROL, 8'h79);
    bus(1'b1, `ADDR_GENERAL_CONTROL, 8'hF3);
    i = rx_count[1];
    bus(1'b1, `ADDR_PORT_B_DATA, 8'hC3);
    rchk(`ADDR_PORT_STATUS, 8'h04, 8'h00);
    repeat (12)
      @(posedge clock);
    rchk(`ADDR_PORT_STATUS, 8'h04, 8'h04);
    chk(8'(rx_count[1] - i), 8'h00);
    tally_and_finish;
  end
  // The whole run needs under two thousand cycles; this allows ten thousand.
  initial
  begin
    #400000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // parallel_port_mode0_output_bitio_tb
